// File: rtl/psram_mode_consts.svh
// named offsets, codes, field positions and reset values of the mode block
`ifndef PSRAM_MODE_CONSTS_SVH
`define PSRAM_MODE_CONSTS_SVH
`define LRC_RESET 8'h40
`define BWC_RESET 8'h05
`define MA_REFRESH_STATUS 8'h03
`define MA_LRC 8'h04
`define MA_POWER 8'h06
`define MA_BWC 8'h08
`define CMD_REG_WRITE 8'hc0
`define CMD_REG_READ 8'h40
`define PWR_SLEEP_CODE 8'hf0
`define PWR_DPD_CODE 8'hc0
`define IDX_INST 6'h00
`define IDX_MA 6'h05
`define IDX_WR_DATA 6'h08
`define IDX_RD_BASE 6'h06
`define IDX_MAX 6'h3f
`define RATE_HALF 2'b01
`define RATE_NORMAL 2'b00
`define RATE_QUAD 2'b10
`define WLC_HI 7
`define WLC_LO 5
`define RFREQ_HI 4
`define RFREQ_LO 3
`define PARTIAL_ARRAY_REFRESH_HI 2
`define PARTIAL_ARRAY_REFRESH_LO 0
`define PARTIAL_ARRAY_REFRESH_NONE 3'h4
`define BWC_TOP 7
`define BWC_X16 6
`define BWC_RBX 3
`define BWC_HYB 2
`define BL_HI 1
`define BL_LO 0
`define RS_RBX 7
`define RS_RATE_HI 5
`define RS_RATE_LO 4
`define PAGE_MASK_X8 11'h7ff
`define PAGE_MASK_X16 11'h3ff
`define WRAP_MASK_16 11'h00f
`define WRAP_MASK_32 11'h01f
`define WRAP_MASK_64 11'h03f
`define ROW_ALL 14'h3fff
`endif

// File: rtl/psram_mode_pkg.sv
// types shared by the mode and power block and its burst address walker
package psram_mode_pkg;
  typedef enum logic [1:0] {
    PW_ACTIVE = 2'b00,
    PW_SLEEP = 2'b01,
    PW_WAKE = 2'b11,
    PW_DPD = 2'b10
  } power_state_t;

  typedef struct packed {
    logic x16;
    logic hybrid;
    logic [1:0] blen;
    logic linear;
    logic is_read;
    logic rbx_en;
  } burst_cfg_t;

  typedef struct packed {
    logic none;
    logic [13:0] lo_row;
    logic [13:0] hi_row;
  } refresh_window_t;
endpackage

// File: rtl/burst_addr_walker.sv
// burst column and row walker: wrap, hybrid wrap, linear and row crossing
`timescale 1ns/100ps
`include "psram_mode_consts.svh"
module burst_addr_walker
  import psram_mode_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic step,
  input wire logic [13:0] start_row,
  input wire logic [10:0] start_col,
  input wire burst_cfg_t cfg,
  output logic [13:0] row_q,
  output logic [10:0] col_q
);
  logic [10:0] cnt_q;
  logic hyb_done_q;
  logic [10:0] pm;
  logic [10:0] wm;
  logic [10:0] col_inc;

  function automatic logic [10:0] page_mask(input logic x16);
    page_mask = x16 ? `PAGE_MASK_X16 : `PAGE_MASK_X8;
  endfunction

  // a linear command behaves as a full-page length whatever is programmed
  function automatic logic [10:0] wrap_mask(input burst_cfg_t c);
    if (c.linear)
      wrap_mask = page_mask(c.x16);
    else
      case (c.blen)
        2'b00: wrap_mask = `WRAP_MASK_16;
        2'b01: wrap_mask = `WRAP_MASK_32;
        2'b10: wrap_mask = `WRAP_MASK_64;
        default: wrap_mask = page_mask(c.x16);
      endcase
  endfunction

  assign pm = page_mask(cfg.x16);
  assign wm = wrap_mask(cfg);
  assign col_inc = 11'(col_q + 11'h001);

  // address walk, one unit per step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      row_q <= 14'h0000;
      col_q <= 11'h000;
      cnt_q <= 11'h000;
      hyb_done_q <= 1'b0;
    end else if (load) begin
      row_q <= start_row;
      col_q <= start_col & pm;
      cnt_q <= 11'h000;
      hyb_done_q <= 1'b0;
    end else if (step) begin
      if (cfg.linear || (cfg.hybrid && hyb_done_q)) begin
        if (col_q == pm) begin
          col_q <= 11'h000;
          // only linear reads may cross rows; writes stay in page
          if (cfg.linear && cfg.is_read && cfg.rbx_en)
            row_q <= 14'(row_q + 14'h0001);
        end else begin
          col_q <= col_inc & pm;
        end
      end else if (cfg.hybrid && cnt_q == wm) begin
        // first pass done: leave the wrapped block at its far end
        col_q <= 11'((col_q & ~wm) + wm + 11'h001) & pm;
        hyb_done_q <= 1'b1;
      end else begin
        col_q <= (col_q & ~wm) | (col_inc & wm);
        cnt_q <= 11'(cnt_q + 11'h001);
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wrap_block: assert property (step && !load && !cfg.linear && !cfg.hybrid
    && cfg.blen == 2'b00 |=> col_q[10:4] == $past(col_q[10:4]))
    else $error("wrap burst left its 16-unit block");
  a_x16_col_mask: assert property (load && cfg.x16 |=> col_q[10] == 1'b0)
    else $error("column bit 10 kept in sixteen-bit mode");
  a_write_in_page: assert property (step && !load && !cfg.is_read
    |=> row_q == $past(row_q))
    else $error("write burst crossed a row");
  c_row_cross: cover property (step && cfg.linear && cfg.is_read
    && cfg.rbx_en && col_q == pm);
endmodule // burst_addr_walker

// File: rtl/psram_mode_config_power_ctrl.sv
// mode registers, refresh status and low-power control of the octal psram
`timescale 1ns/100ps
`include "psram_mode_consts.svh"
module psram_mode_config_power_ctrl
  import psram_mode_pkg::*;
#(
  parameter int RD_LAT = 5,
  parameter bit ROW_CROSS_SUPPORTED = 1'b1
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic ce_n,
  input wire logic sclk,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  output logic dqs_out,
  output logic dqs_oe,
  input wire logic temp_allow_normal,
  input wire logic temp_allow_half,
  input wire logic burst_load,
  input wire logic burst_step,
  input wire logic burst_linear,
  input wire logic burst_is_read,
  input wire logic [13:0] start_row,
  input wire logic [10:0] start_col,
  output logic [13:0] row_addr,
  output logic [10:0] col_addr,
  output logic [2:0] write_latency_cycles,
  output logic x16_mode,
  output refresh_window_t refresh_window,
  output logic [1:0] refresh_rate,
  output power_state_t power_state,
  output logic data_retain
);
  localparam logic [5:0] IDX_RD = 6'(`IDX_RD_BASE + 2 * RD_LAT);

  // the read data phase must fit the frame edge counter
  if (RD_LAT < 3 || RD_LAT > 7) begin : g_bad_lat
    $error("RD_LAT must lie between 3 and 7");
  end

  logic rst_s1_q, rst_n;
  logic ce_s1_q, ce_s2_q, ce_s3_q;
  logic sclk_s1_q, sclk_s2_q, sclk_s3_q;
  logic [7:0] dq_s1_q, dq_s2_q;
  logic link_edge, ce_rise, ce_fall;
  logic [5:0] edge_cnt_q;
  logic frame_ok_q;
  logic [7:0] inst_q, ma_q;
  logic [7:0] lrc_q, bwc_q;
  logic [1:0] rate_q;
  logic arm_sleep_q, arm_dpd_q;
  power_state_t state_q;
  logic reg_wr, rd_start;
  logic [7:0] rd_data;
  logic [2:0] wlc_q;
  refresh_window_t win_q;
  burst_cfg_t bcfg;

  // reset release is synchronised so all flops leave reset together
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // pin synchronisers; only stage two and later are looked at
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_s1_q <= 1'b1;
      ce_s2_q <= 1'b1;
      ce_s3_q <= 1'b1;
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      ce_s1_q <= ce_n;
      ce_s2_q <= ce_s1_q;
      ce_s3_q <= ce_s2_q;
      sclk_s1_q <= sclk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
    end
  end

  // both link clock edges carry a byte (double data rate)
  assign link_edge = !ce_s2_q && (sclk_s2_q != sclk_s3_q);
  assign ce_rise = ce_s2_q && !ce_s3_q;
  assign ce_fall = !ce_s2_q && ce_s3_q;
  assign reg_wr = link_edge && frame_ok_q && edge_cnt_q == `IDX_WR_DATA
    && inst_q == `CMD_REG_WRITE;
  assign rd_start = link_edge && frame_ok_q && edge_cnt_q == IDX_RD
    && inst_q == `CMD_REG_READ;

  // frame tracking; frames that start outside active state are not decoded
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_cnt_q <= 6'h00;
      frame_ok_q <= 1'b0;
      inst_q <= 8'h00;
      ma_q <= 8'h00;
    end else begin
      if (ce_s2_q) begin
        edge_cnt_q <= 6'h00;
        frame_ok_q <= 1'b0;
      end else if (link_edge && edge_cnt_q != `IDX_MAX) begin
        edge_cnt_q <= 6'(edge_cnt_q + 6'h01);
      end
      if (ce_fall)
        frame_ok_q <= (state_q == PW_ACTIVE);
      if (link_edge && edge_cnt_q == `IDX_INST)
        inst_q <= dq_s2_q;
      if (link_edge && edge_cnt_q == `IDX_MA)
        ma_q <= dq_s2_q;
    end
  end

  // writable mode registers; power-down exit restores both defaults
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lrc_q <= `LRC_RESET;
      bwc_q <= `BWC_RESET;
    end else if (state_q == PW_DPD && ce_fall) begin
      lrc_q <= `LRC_RESET;
      bwc_q <= `BWC_RESET;
    end else if (reg_wr) begin
      if (ma_q == `MA_LRC)
        lrc_q <= dq_s2_q;
      if (ma_q == `MA_BWC) begin
        bwc_q <= dq_s2_q;
        bwc_q[`BWC_TOP] <= 1'b0;
      end
    end
  end

  // power command arms an entry that the closing chip-select edge starts
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arm_sleep_q <= 1'b0;
      arm_dpd_q <= 1'b0;
    end else if (reg_wr && ma_q == `MA_POWER) begin
      arm_sleep_q <= (dq_s2_q == `PWR_SLEEP_CODE);
      arm_dpd_q <= (dq_s2_q == `PWR_DPD_CODE);
    end else if (ce_rise) begin
      arm_sleep_q <= 1'b0;
      arm_dpd_q <= 1'b0;
    end
  end

  // power states; wake holds off decoding until chip select is high again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= PW_ACTIVE;
    end else begin
      case (state_q)
        PW_ACTIVE: begin
          if (ce_rise && arm_sleep_q)
            state_q <= PW_SLEEP;
          else if (ce_rise && arm_dpd_q)
            state_q <= PW_DPD;
        end
        PW_SLEEP: begin
          if (ce_fall)
            state_q <= PW_WAKE;
        end
        PW_DPD: begin
          if (ce_fall)
            state_q <= PW_WAKE;
        end
        PW_WAKE: begin
          if (ce_rise)
            state_q <= PW_ACTIVE;
        end
        default: state_q <= PW_ACTIVE;
      endcase
    end
  end

  // decode of the latency code; reserved codes report zero
  function automatic logic [2:0] wl_decode(input logic [2:0] code);
    case (code)
      3'h0: wl_decode = 3'h3;
      3'h4: wl_decode = 3'h4;
      3'h2: wl_decode = 3'h5;
      3'h6: wl_decode = 3'h6;
      3'h1: wl_decode = 3'h7;
      default: wl_decode = 3'h0;
    endcase
  endfunction

  // partition bounds in rows; a column bit never splits a partition
  function automatic refresh_window_t partial_array_refresh_window(input logic [2:0] code);
    logic [13:0] span;
    span = `ROW_ALL >> code[1:0];
    partial_array_refresh_window.none = (code == `PARTIAL_ARRAY_REFRESH_NONE);
    if (code[2] && code[1:0] != 2'b00) begin
      partial_array_refresh_window.lo_row = ~span; // top partitions
      partial_array_refresh_window.hi_row = `ROW_ALL;
    end else begin
      partial_array_refresh_window.lo_row = 14'h0000;
      partial_array_refresh_window.hi_row = span;
    end
  endfunction

  // refresh rate follows the setting, held back by temperature
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_q <= `RATE_QUAD;
    end else if (!lrc_q[`RFREQ_LO]) begin
      rate_q <= `RATE_QUAD;
    end else if (lrc_q[`RFREQ_HI] && temp_allow_half) begin
      rate_q <= `RATE_HALF;
    end else if (temp_allow_normal) begin
      rate_q <= `RATE_NORMAL;
    end else begin
      rate_q <= `RATE_QUAD;
    end
  end

  // decoded settings are registered for the array side
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wlc_q <= 3'h0;
      win_q <= '0;
    end else begin
      wlc_q <= wl_decode(lrc_q[`WLC_HI:`WLC_LO]);
      win_q <= partial_array_refresh_window(lrc_q[`PARTIAL_ARRAY_REFRESH_HI:`PARTIAL_ARRAY_REFRESH_LO]);
    end
  end

  // read mux; the power command register reads as zero
  always_comb begin
    rd_data = 8'h00;
    case (ma_q)
      `MA_REFRESH_STATUS: begin
        rd_data[`RS_RBX] = ROW_CROSS_SUPPORTED;
        rd_data[`RS_RATE_HI:`RS_RATE_LO] = rate_q;
      end
      `MA_LRC: rd_data = lrc_q;
      `MA_BWC: rd_data = bwc_q;
      default: rd_data = 8'h00;
    endcase
  end

  // read data drives lanes 7:0 only, strobe toggling each link edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_out <= 8'h00;
      dq_oe <= 1'b0;
      dqs_out <= 1'b0;
      dqs_oe <= 1'b0;
    end else if (ce_s2_q) begin
      dq_oe <= 1'b0;
      dqs_oe <= 1'b0;
      dqs_out <= 1'b0;
    end else if (rd_start) begin
      dq_out <= rd_data;
      dq_oe <= 1'b1;
      dqs_oe <= 1'b1;
      dqs_out <= 1'b1;
    end else if (link_edge && dq_oe) begin
      dqs_out <= ~dqs_out;
    end
  end

  assign bcfg.x16 = bwc_q[`BWC_X16];
  assign bcfg.hybrid = bwc_q[`BWC_HYB];
  assign bcfg.blen = bwc_q[`BL_HI:`BL_LO];
  assign bcfg.linear = burst_linear;
  assign bcfg.is_read = burst_is_read;
  assign bcfg.rbx_en = bwc_q[`BWC_RBX] & ROW_CROSS_SUPPORTED;

  burst_addr_walker u_walker (
    .clk(ref_clk),
    .rst_n(rst_n),
    .load(burst_load),
    .step(burst_step),
    .start_row(start_row),
    .start_col(start_col),
    .cfg(bcfg),
    .row_q(row_addr),
    .col_q(col_addr)
  );

  assign write_latency_cycles = wlc_q;
  assign x16_mode = bwc_q[`BWC_X16];
  assign refresh_window = win_q;
  assign refresh_rate = rate_q;
  assign power_state = state_q;
  assign data_retain = (state_q != PW_DPD);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_quad_rate: assert property (!lrc_q[`RFREQ_LO] && $stable(lrc_q)
    |=> rate_q == `RATE_QUAD)
    else $error("refresh flag not quadruple for x0 setting");
  a_latency_decode: assert property ($past(lrc_q[7:5]) == 3'b001
    |-> wlc_q == 3'h7)
    else $error("latency code 001 not decoded as 7");
  a_sleep_entry: assert property (state_q == PW_ACTIVE && ce_rise
    && arm_sleep_q |=> state_q == PW_SLEEP && data_retain)
    else $error("sleep not entered on chip select rise");
  a_sleep_exit: assert property (state_q == PW_SLEEP && ce_fall
    |=> state_q == PW_WAKE ##0 data_retain)
    else $error("sleep not left on chip select low");
  a_dpd_defaults: assert property (state_q == PW_DPD && ce_fall
    |=> lrc_q == `LRC_RESET && bwc_q == `BWC_RESET)
    else $error("registers not restored after power-down exit");
  a_reg_write_wl1: assert property (reg_wr && ma_q == `MA_LRC
    && state_q == PW_ACTIVE |=> lrc_q == $past(dq_s2_q))
    else $error("register write not taken at latency one");
  a_bwc_top_zero: assert property (reg_wr && ma_q == `MA_BWC
    |=> !bwc_q[`BWC_TOP] && x16_mode == $past(dq_s2_q[6]))
    else $error("width bit or top bit wrong after write");
  a_partial_array_refresh_none: assert property (lrc_q[2:0] == 3'b100
    |=> refresh_window.none)
    else $error("partial refresh none not flagged");
  a_read_lanes: assert property (rd_start |=> dq_oe && dqs_oe
    && dq_out == $past(rd_data))
    else $error("register read not driven on low lanes");
  c_sleep: cover property (state_q == PW_SLEEP ##[1:200] state_q == PW_WAKE);
  c_dpd: cover property (state_q == PW_DPD ##[1:200] state_q == PW_WAKE);
  c_reg_write: cover property (reg_wr && ma_q == `MA_BWC);
  c_reg_read: cover property (rd_start && ma_q == `MA_REFRESH_STATUS);
endmodule // psram_mode_config_power_ctrl

// File: verification/host_link_model.sv
// host link model: register frames and power pulses on the octal link
`timescale 1ns/100ps
`include "psram_mode_consts.svh"
module host_link_model #(
  parameter int RD_LAT = 5,
  parameter int GAP_CYC = 6,
  parameter int HOLD_CYC = 12,
  parameter int EXIT_CYC = 12,
  parameter int REPEAT_CYC = 20
) (
  input wire logic ref_clk,
  output logic ce_n,
  output logic sclk,
  output logic [7:0] dq_in,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_oe
);
  logic [7:0] last_q;

  // link idle: chip select high, clock parked low
  initial begin
    ce_n = 1'b1;
    sclk = 1'b0;
    dq_in = 8'h00;
    last_q = 8'h00;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // byte set a cycle ahead of its edge and held four after; 12.5 MHz link
  task automatic edge_out(input logic [7:0] b);
    dq_in = b;
    last_q = b;
    cyc(1);
    sclk = ~sclk;
    cyc(4);
  endtask

  // don't-care slots carry the inverse so stale data never looks valid
  task automatic idle_out(input int n);
    repeat (n) edge_out(~last_q);
  endtask

  task automatic open_frame(input logic [7:0] inst, input logic [7:0] ma);
    cyc(1);
    ce_n = 1'b0;
    cyc(2);
    edge_out(inst);
    idle_out(4);
    edge_out(ma);
  endtask

  // frames use an even edge count, so the clock parks low again
  task automatic close_frame();
    ce_n = 1'b1;
    dq_in = ~last_q;
    cyc(GAP_CYC);
  endtask

  task automatic reg_write(input logic [7:0] ma, input logic [7:0] d);
    open_frame(`CMD_REG_WRITE, ma);
    idle_out(2);
    edge_out(d);
    idle_out(1);
    close_frame();
  endtask

  task automatic reg_read(input logic [7:0] ma, output logic [7:0] d,
      output logic oe);
    open_frame(`CMD_REG_READ, ma);
    idle_out(2 * RD_LAT + 2);
    d = dq_out;
    oe = dq_oe & dqs_oe;
    close_frame();
  endtask

  // entry write, then chip select stays high for the minimum time
  task automatic power_enter(input logic [7:0] code);
    if (code == `PWR_DPD_CODE)
      cyc(REPEAT_CYC);
    reg_write(`MA_POWER, code);
    cyc(HOLD_CYC);
  endtask

  // low pulse wakes the part; no frame until the exit time has run
  task automatic exit_pulse();
    cyc(1);
    ce_n = 1'b0;
    cyc(4);
    ce_n = 1'b1;
    cyc(EXIT_CYC);
  endtask
endmodule // host_link_model

// File: verification/tb.sv
// testbench: mode registers, burst walker and power states over the link
`timescale 1ns/100ps
`include "psram_mode_consts.svh"
module tb
  import psram_mode_pkg::*;
;
  localparam int RD_LAT = 5;
  logic ref_clk, resetn, ce_n, sclk, dq_oe, dqs_out, dqs_oe;
  logic [7:0] dq_in, dq_out;
  logic temp_allow_normal, temp_allow_half, burst_load, burst_step;
  logic burst_linear, burst_is_read, x16_mode, data_retain;
  logic [13:0] start_row, row_addr;
  logic [10:0] start_col, col_addr;
  logic [2:0] write_latency_cycles;
  logic [1:0] refresh_rate;
  refresh_window_t refresh_window;
  power_state_t power_state;
  int fail_count = 0;
  int total_checks = 0;

  psram_mode_config_power_ctrl #(.RD_LAT(RD_LAT)) dut (.ref_clk, .resetn,
    .ce_n, .sclk, .dq_in, .dq_out, .dq_oe, .dqs_out, .dqs_oe,
    .temp_allow_normal, .temp_allow_half, .burst_load, .burst_step,
    .burst_linear, .burst_is_read, .start_row, .start_col, .row_addr,
    .col_addr, .write_latency_cycles, .x16_mode, .refresh_window,
    .refresh_rate, .power_state, .data_retain);

  host_link_model #(.RD_LAT(RD_LAT)) host (.ref_clk, .ce_n, .sclk, .dq_in,
    .dq_out, .dq_oe, .dqs_oe);

  // 125 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] ma, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    host.reg_read(ma, d, oe);
    check(16'(oe), 16'h0001);
    check(16'(d), 16'(exp));
    // the frame closed: both lanes and the strobe must be released
    check(16'({dq_oe, dqs_oe}), 16'h0000);
    // strobe rose at the data edge and toggled once on the last edge
    check(16'(dqs_out), 16'h0000);
  endtask

  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_state(input power_state_t s);
    int i;
    for (i = 0; i < 40; i++) begin
      if (power_state === s)
        break;
      @(negedge ref_clk);
    end
    check(16'(power_state), 16'(s));
    if (i == 40)
      complete_run();
  endtask

  task automatic t_reset();
    rd(`MA_REFRESH_STATUS, 8'ha0);
    rd(`MA_LRC, `LRC_RESET);
    rd(`MA_BWC, `BWC_RESET);
    check(16'(write_latency_cycles), 16'h0005);
    check(16'(x16_mode), 16'h0000);
  endtask

  task automatic t_latency();
    logic [2:0] wl [8] = '{3'h3, 3'h7, 3'h5, 3'h0, 3'h4, 3'h0, 3'h6, 3'h0};
    for (int c = 0; c < 8; c++) begin
      host.reg_write(`MA_LRC, {3'(c), 5'h00});
      check(16'(write_latency_cycles), 16'(wl[c]));
      rd(`MA_LRC, {3'(c), 5'h00});
    end
    host.reg_write(`MA_LRC, `LRC_RESET);
  endtask

  // rows: refresh field, normal allowed, half allowed, expected rate
  task automatic t_refresh();
    logic [5:0] t [6] = '{6'b001110, 6'b101110, 6'b011000, 6'b010010,
                          6'b111101, 6'b111000};
    for (int i = 0; i < 6; i++) begin
      temp_allow_normal = t[i][3];
      temp_allow_half = t[i][2];
      host.reg_write(`MA_LRC, {3'b010, t[i][5:4], 3'b000});
      check(16'(refresh_rate), 16'(t[i][1:0]));
      rd(`MA_REFRESH_STATUS, {2'b10, t[i][1:0], 4'h0});
    end
    temp_allow_normal = 1'b1;
    temp_allow_half = 1'b1;
  endtask

  task automatic t_partial_array_refresh();
    logic [13:0] m;
    for (int c = 0; c < 8; c++) begin
      host.reg_write(`MA_LRC, {5'b01000, 3'(c)});
      m = 14'h3fff >> c[1:0];
      check(16'(refresh_window.none), 16'(c == 4));
      if (c != 4) begin
        check(16'(refresh_window.lo_row), c > 4 ? {2'b00, ~m} : 16'h0000);
        check(16'(refresh_window.hi_row), c > 4 ? 16'h3fff : {2'b00, m});
      end
    end
    host.reg_write(`MA_LRC, `LRC_RESET);
  endtask

  task automatic t_regs();
    host.reg_write(`MA_REFRESH_STATUS, 8'h00);
    rd(`MA_REFRESH_STATUS, 8'ha0);
    rd(`MA_POWER, 8'h00);
    rd(8'h05, 8'h00);
    host.reg_write(`MA_BWC, 8'h45);
    check(16'(x16_mode), 16'h0001);
    rd(`MA_BWC, 8'h45);
    host.reg_write(`MA_BWC, `BWC_RESET);
    check(16'(x16_mode), 16'h0000);
  endtask

  // load a start address, step n units, compare the final address
  task automatic walk(input logic [7:0] cfg, input logic lin, is_rd,
      input logic [10:0] col, input int n, input logic [13:0] er,
      input logic [10:0] ec);
    host.reg_write(`MA_BWC, cfg);
    burst_linear = lin;
    burst_is_read = is_rd;
    start_col = col;
    burst_load = 1'b1;
    @(negedge ref_clk);
    burst_load = 1'b0;
    burst_step = 1'b1;
    repeat (n) @(negedge ref_clk);
    burst_step = 1'b0;
    check(16'(row_addr), 16'(er));
    check(16'(col_addr), 16'(ec));
  endtask

  task automatic t_walk();
    walk(8'h00, 0, 0, 11'h004, 12, 14'h0005, 11'h000);
    walk(8'h01, 0, 0, 11'h004, 28, 14'h0005, 11'h000);
    walk(8'h02, 0, 0, 11'h004, 60, 14'h0005, 11'h000);
    walk(8'h03, 0, 0, 11'h004, 2044, 14'h0005, 11'h000);
    walk(8'h04, 0, 0, 11'h002, 16, 14'h0005, 11'h010);
    walk(8'h05, 0, 0, 11'h002, 32, 14'h0005, 11'h020);
    walk(8'h04, 0, 0, 11'h002, 2048, 14'h0005, 11'h000);
    walk(8'h44, 0, 0, 11'h002, 1024, 14'h0005, 11'h000);
    walk(8'h00, 1, 0, 11'h7fe, 2, 14'h0005, 11'h000);
    walk(8'h08, 1, 1, 11'h7fe, 2, 14'h0006, 11'h000);
    walk(8'h08, 1, 0, 11'h7fe, 2, 14'h0005, 11'h000);
    walk(8'h48, 1, 1, 11'h3fe, 2, 14'h0006, 11'h000);
    host.reg_write(`MA_BWC, `BWC_RESET);
  endtask

  task automatic t_power();
    host.reg_write(`MA_LRC, 8'h28);
    host.power_enter(8'ha5);
    check(16'(power_state), 16'(PW_ACTIVE));
    host.power_enter(`PWR_SLEEP_CODE);
    wait_state(PW_SLEEP);
    check(16'(data_retain), 16'h0001);
    host.exit_pulse();
    wait_state(PW_ACTIVE);
    rd(`MA_LRC, 8'h28);
    host.reg_write(`MA_BWC, 8'h4d);
    host.power_enter(`PWR_DPD_CODE);
    wait_state(PW_DPD);
    check(16'(data_retain), 16'h0000);
    host.exit_pulse();
    wait_state(PW_ACTIVE);
    rd(`MA_LRC, `LRC_RESET);
    rd(`MA_BWC, `BWC_RESET);
    check(16'(write_latency_cycles), 16'h0005);
    check(16'(x16_mode), 16'h0000);
  endtask

  // reset for four cycles, then the scenarios in turn
  initial begin
    resetn = 1'b0;
    temp_allow_normal = 1'b1;
    temp_allow_half = 1'b1;
    burst_load = 1'b0;
    burst_step = 1'b0;
    burst_linear = 1'b0;
    burst_is_read = 1'b0;
    start_row = 14'h0005;
    start_col = 11'h000;
    repeat (4) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (8) @(negedge ref_clk);
    t_reset();
    t_latency();
    t_refresh();
    t_partial_array_refresh();
    t_regs();
    t_walk();
    t_power();
    complete_run();
  end
endmodule // tb
